/* verilog/rtw_consts.vh */
// Constants for the third timer and wake-up timer control block
`ifndef RTW_CONSTS_VH
`define RTW_CONSTS_VH
// Register addresses
`define RTW_A_T3_CTRL 8'h1e
`define RTW_A_RLD_HI 8'h1f
`define RTW_A_RLD_LO 8'h20
`define RTW_A_CNT_HI 8'h21
`define RTW_A_CNT_LO 8'h22
`define RTW_A_WK_CTRL 8'h23
`define RTW_A_IRQ_STAT 8'h30
`define RTW_A_IRQ_CLR 8'h31
`define RTW_A_IRQ_EN 8'h32
`define RTW_A_CMD 8'h33
// Timer three control fields
`define RTW_T3_STOPRX 7
`define RTW_T3_START_HI 5
`define RTW_T3_START_LO 4
`define RTW_T3_AUTO 3
`define RTW_T3_CLK_HI 1
`define RTW_T3_CLK_LO 0
`define RTW_T3_CTRL_MASK 8'hbb
`define RTW_T3_CTRL_RST 8'h00
// Start modes
`define RTW_SM_NONE 2'b00
`define RTW_SM_TXEND 2'b01
`define RTW_SM_TRIM_NOUF 2'b10
`define RTW_SM_TRIM_UF 2'b11
// Wake-up control fields
`define RTW_WK_RUN 7
`define RTW_WK_QUAL 6
`define RTW_WK_CFG_HI 5
`define RTW_WK_CFG_RST 6'h00
// Command bits
`define RTW_CMD_START 0
`define RTW_CMD_STOP 1
// Interrupt bits
`define RTW_IRQ_UF 0
`define RTW_IRQ_RXSTOP 1
`define RTW_IRQ_W 2
// Carrier tick: clock rate and carrier rate in kHz
`define RTW_CLK_KHZ 17'd100000
`define RTW_CAR_KHZ 17'd13560
// 211.875 kHz is the carrier divided by 64
`define RTW_SLOW_DIV_MAX 6'h3f
// Low-frequency divider taps
`define RTW_DIV8_MAX 3'h7
`define RTW_DIV16_MAX 4'hf
`define RTW_DIV32_MAX 5'h1f
`endif

/* verilog/rtw_tick_gen.v */
// Carrier-rate and 211.875 kHz tick generator from the system clock
`timescale 1ns/100ps
`default_nettype none
`include "rtw_consts.vh"
module rtw_tick_gen (
   input wire clk_in, // System clock
   input wire rst_n_in, // Async reset, active low
   input wire ce_in, // Clock enable
   output reg car_tick_out, // One pulse per carrier period
   output reg slow_tick_out // One pulse per 64 carrier periods
);
   reg [16:0] acc_r;
   reg [5:0] div_r;
   wire [17:0] acc_sum;
   wire car_wrap;

   // Fractional accumulator: the mean rate is exact, jitter is one cycle
   assign acc_sum = {1'b0, acc_r} + {1'b0, `RTW_CAR_KHZ};
   assign car_wrap = acc_sum >= {1'b0, `RTW_CLK_KHZ};

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_r <= 17'h0;
         div_r <= 6'h0;
         car_tick_out <= 1'b0;
         slow_tick_out <= 1'b0;
      end else if (ce_in) begin
         car_tick_out <= car_wrap;
         slow_tick_out <= car_wrap && (div_r == `RTW_SLOW_DIV_MAX);
         if (car_wrap) begin
            acc_r <= acc_sum[16:0] - `RTW_CLK_KHZ;
            div_r <= div_r + 6'h1;
         end else begin
            acc_r <= acc_sum[16:0];
         end
      end
   end
endmodule
`default_nettype wire

/* verilog/rtw_timer3_wakeup.v */
// Third down-counting timer and wake-up timer control with register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rtw_consts.vh"
module rtw_timer3_wakeup (
   input wire clk_in, // System clock, 100 MHz
   input wire rst_n_in, // Async reset, active low
   input wire ce_in, // Clock enable, freezes all state when low
   input wire [7:0] addr_in, // Register address
   input wire [7:0] wdata_in, // Register write data
   input wire wr_in, // Write strobe
   input wire rd_in, // Read strobe
   output reg [7:0] rdata_out, // Read data, cycle after read strobe
   input wire t0_underflow_in, // Timer zero underflow pulse
   input wire t1_underflow_in, // Timer one underflow pulse
   input wire tx_end_in, // End of transmission pulse
   input wire rx_nibble_in, // First four bits received pulse
   input wire lfo_clk_in, // Low-frequency oscillator clock pin
   output reg t3_underflow_out, // Timer three underflow pulse
   output reg t3_running_out, // Timer three is counting
   output reg wk_running_out, // Wake-up timer running flag
   output reg [5:0] wk_cfg_out, // Wake-up control bits 5..0
   output reg wk_tick_out, // Wake-up timer count tick
   output reg irq_out // Interrupt, high while enabled status set
);
   // Picks one of four tick sources by a two-bit select
   function sel_tick;
      input [1:0] sel;
      input a;
      input b;
      input c;
      input d;
      begin
         case (sel)
            2'b00: sel_tick = a;
            2'b01: sel_tick = b;
            2'b10: sel_tick = c;
            default: sel_tick = d;
         endcase
      end
   endfunction

   reg [7:0] t3_ctrl_r;
   reg [7:0] rld_hi_r;
   reg [7:0] rld_lo_r;
   reg [15:0] cnt_r;
   reg [15:0] cnt_nxt;
   reg run_r;
   reg run_nxt;
   reg uf_nxt;
   reg rxstop_nxt;
   reg wk_run_r;
   reg [5:0] wk_cfg_r;
   reg [4:0] lfo_div_r;
   reg lfo_s1_r;
   reg lfo_s2_r;
   reg lfo_s3_r;
   reg [1:0] irq_stat_r;
   reg [1:0] irq_en_r;
   reg [1:0] stat_nxt;
   reg [1:0] en_nxt;
   reg [7:0] rdata_nxt;
   wire car_tick;
   wire slow_tick;
   wire lfo_rise;
   wire t3_tick;
   wire wk_tick;
   wire wr_cmd;
   wire sw_start;
   wire sw_stop;
   wire [1:0] start_mode;
   wire trimming;
   wire trim_edge;
   wire start_ev;

   rtw_tick_gen u_tick (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .car_tick_out(car_tick),
      .slow_tick_out(slow_tick)
   );

   // Second and third stages feed the edge detector; first stage feeds only the second
   assign lfo_rise = lfo_s2_r && !lfo_s3_r;

   assign start_mode = t3_ctrl_r[`RTW_T3_START_HI:`RTW_T3_START_LO];
   assign trimming = start_mode[1];
   assign t3_tick = sel_tick(t3_ctrl_r[`RTW_T3_CLK_HI:`RTW_T3_CLK_LO],
      car_tick, slow_tick, t0_underflow_in, t1_underflow_in);
   assign wr_cmd = wr_in && (addr_in == `RTW_A_CMD);
   assign sw_start = wr_cmd && wdata_in[`RTW_CMD_START];
   assign sw_stop = wr_cmd && wdata_in[`RTW_CMD_STOP];
   // Trimming toggles run state on each rising oscillator edge
   assign trim_edge = trimming && lfo_rise;
   assign start_ev = sw_start ||
      (start_mode == `RTW_SM_TXEND && tx_end_in) ||
      (trim_edge && !run_r);

   assign wk_tick = sel_tick(wk_cfg_r[1:0], lfo_rise,
      lfo_rise && lfo_div_r[2:0] == `RTW_DIV8_MAX,
      lfo_rise && lfo_div_r[3:0] == `RTW_DIV16_MAX,
      lfo_rise && lfo_div_r == `RTW_DIV32_MAX);

   // Timer three next state
   always @* begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      uf_nxt = 1'b0;
      rxstop_nxt = 1'b0;
      if (start_ev) begin
         cnt_nxt = {rld_hi_r, rld_lo_r};
         run_nxt = 1'b1;
      end else if (sw_stop || (trim_edge && run_r)) begin
         run_nxt = 1'b0;
      end else if (run_r && t3_ctrl_r[`RTW_T3_STOPRX] && !trimming &&
            rx_nibble_in) begin
         run_nxt = 1'b0;
         rxstop_nxt = 1'b1;
      end else if (run_r && t3_tick) begin
         if (cnt_r == 16'h0) begin
            // Trim without underflow raises nothing; it reloads with auto, else stops at zero
            if (start_mode != `RTW_SM_TRIM_NOUF) begin
               uf_nxt = 1'b1;
            end
            if (t3_ctrl_r[`RTW_T3_AUTO]) begin
               cnt_nxt = {rld_hi_r, rld_lo_r};
            end else begin
               run_nxt = 1'b0;
            end
         end else begin
            cnt_nxt = cnt_r - 16'h1;
         end
      end
   end

   // Interrupt next state; a new event wins over a clear
   always @* begin
      stat_nxt = irq_stat_r;
      en_nxt = irq_en_r;
      if (wr_in && addr_in == `RTW_A_IRQ_CLR) begin
         stat_nxt = irq_stat_r & ~wdata_in[`RTW_IRQ_W-1:0];
      end
      if (wr_in && addr_in == `RTW_A_IRQ_EN) begin
         en_nxt = wdata_in[`RTW_IRQ_W-1:0];
      end
      stat_nxt[`RTW_IRQ_UF] = stat_nxt[`RTW_IRQ_UF] | uf_nxt;
      stat_nxt[`RTW_IRQ_RXSTOP] = stat_nxt[`RTW_IRQ_RXSTOP] | rxstop_nxt;
   end

   // Read mux; count bytes are live, software must not read during
   // reception since the two bytes are not captured together
   always @* begin
      rdata_nxt = 8'h00;
      case (addr_in)
         `RTW_A_T3_CTRL: rdata_nxt = t3_ctrl_r & `RTW_T3_CTRL_MASK;
         `RTW_A_RLD_HI: rdata_nxt = rld_hi_r;
         `RTW_A_RLD_LO: rdata_nxt = rld_lo_r;
         `RTW_A_CNT_HI: rdata_nxt = cnt_r[15:8];
         `RTW_A_CNT_LO: rdata_nxt = cnt_r[7:0];
         `RTW_A_WK_CTRL: rdata_nxt = {wk_run_r, 1'b0, wk_cfg_r};
         `RTW_A_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
         `RTW_A_IRQ_EN: rdata_nxt = {6'h00, irq_en_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         t3_ctrl_r <= `RTW_T3_CTRL_RST;
         rld_hi_r <= 8'h00;
         rld_lo_r <= 8'h00;
         cnt_r <= 16'h0000;
         run_r <= 1'b0;
         wk_run_r <= 1'b0;
         wk_cfg_r <= `RTW_WK_CFG_RST;
         lfo_div_r <= 5'h00;
         lfo_s1_r <= 1'b0;
         lfo_s2_r <= 1'b0;
         lfo_s3_r <= 1'b0;
         irq_stat_r <= 2'b00;
         irq_en_r <= 2'b00;
         rdata_out <= 8'h00;
         t3_underflow_out <= 1'b0;
         t3_running_out <= 1'b0;
         wk_running_out <= 1'b0;
         wk_cfg_out <= `RTW_WK_CFG_RST;
         wk_tick_out <= 1'b0;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         lfo_s1_r <= lfo_clk_in;
         lfo_s2_r <= lfo_s1_r;
         lfo_s3_r <= lfo_s2_r;
         if (wr_in) begin
            case (addr_in)
               `RTW_A_T3_CTRL:
                  t3_ctrl_r <= wdata_in & `RTW_T3_CTRL_MASK;
               // Reload bytes never touch the live counter
               `RTW_A_RLD_HI: rld_hi_r <= wdata_in;
               `RTW_A_RLD_LO: rld_lo_r <= wdata_in;
               `RTW_A_WK_CTRL: begin
                  wk_cfg_r <= wdata_in[`RTW_WK_CFG_HI:0];
                  if (wdata_in[`RTW_WK_QUAL]) begin
                     wk_run_r <= wdata_in[`RTW_WK_RUN];
                  end
               end
               default: wk_run_r <= wk_run_r;
            endcase
         end
         // Divider restarts while stopped so the first period is whole
         if (!wk_run_r) begin
            lfo_div_r <= 5'h00;
         end else if (lfo_rise) begin
            lfo_div_r <= lfo_div_r + 5'h01;
         end
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         irq_stat_r <= stat_nxt;
         irq_en_r <= en_nxt;
         if (rd_in) begin
            rdata_out <= rdata_nxt;
         end else begin
            rdata_out <= 8'h00;
         end
         t3_underflow_out <= uf_nxt;
         t3_running_out <= run_nxt;
         wk_running_out <= wk_run_r;
         wk_cfg_out <= wk_cfg_r;
         wk_tick_out <= wk_run_r && wk_tick;
         irq_out <= |(stat_nxt & en_nxt);
      end
   end
endmodule
`default_nettype wire

/* verification/rtw_timer3_wakeup_properties.sv */
// Port-level timing properties of the timer three and wake-up block
`timescale 1ns/100ps
`default_nettype none
module rtw_timer3_wakeup_properties (
   input wire clk_in, // Clock
   input wire rst_n_in, // Reset, active low
   input wire [7:0] addr_in, // Address
   input wire [7:0] wdata_in, // Write data
   input wire wr_in, // Write strobe
   input wire rd_in, // Read strobe
   input wire [7:0] rdata_out, // Read data
   input wire tx_end_in, // Transmit end
   input wire rx_nibble_in, // Receive nibble
   input wire lfo_clk_in, // Slow clock pin
   input wire t3_underflow_out, // Underflow pulse
   input wire t3_running_out, // Timer running
   input wire wk_running_out, // Wake-up running
   input wire [5:0] wk_cfg_out, // Wake-up config
   input wire wk_tick_out, // Wake-up tick
   input wire irq_out // Interrupt
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Status outputs may lag their cause by one or two cycles, and the oscillator pin by three or five
   rd_idle_zero_a:
   assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   uf_when_run_a:
   assert property (t3_underflow_out |-> t3_running_out
      || $past(t3_running_out)) else $error("underflow while stopped");
   start_cause_a:
   assert property ($rose(t3_running_out) |-> $past(wr_in) || $past(wr_in, 2)
      || $past(tx_end_in) || $past(tx_end_in, 2) || $past(lfo_clk_in, 3)
      || $past(lfo_clk_in, 5)) else $error("timer started without cause");
   stop_cause_a:
   assert property ($fell(t3_running_out) |-> t3_underflow_out
      || $past(t3_underflow_out) || $past(wr_in) || $past(wr_in, 2)
      || $past(rx_nibble_in) || $past(rx_nibble_in, 2)
      || $past(lfo_clk_in, 3) || $past(lfo_clk_in, 5))
      else $error("timer stopped without cause");
   wk_run_qual_a:
   assert property ($changed(wk_running_out) |-> $past(wr_in, 2)
      && $past(addr_in, 2) == 8'h23 && $past(wdata_in[6], 2)
      && wk_running_out == $past(wdata_in[7], 2))
      else $error("wake-up run flag changed without qualifier");
   wk_cfg_write_a:
   assert property ($changed(wk_cfg_out) |-> $past(wr_in, 2)
      && $past(addr_in, 2) == 8'h23 && wk_cfg_out == $past(wdata_in[5:0], 2))
      else $error("wake-up config changed without write");
   irq_fall_a:
   assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
      else $error("interrupt dropped without write");
   irq_rise_a:
   assert property ($rose(irq_out) |-> $past(wr_in) || t3_underflow_out
      || $past(t3_underflow_out) || $past(rx_nibble_in)
      || $past(rx_nibble_in, 2)) else $error("interrupt rose without event");
   wk_tick_run_a:
   assert property (wk_tick_out |-> wk_running_out || $past(wk_running_out))
      else $error("wake-up tick while stopped");
endmodule
`default_nettype wire

/* verification/test_rtw_timer3_wakeup.sv */
// Self-checking bench for the timer three and wake-up control block
`timescale 1ns/100ps
`default_nettype none
module test_rtw_timer3_wakeup;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [3:0] ev = 4'h0;
   logic low_freq_oscillator = 1'b0;
   logic ce = 1'b1;
   logic [7:0] v;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_tick = 0;
   int n_uf = 0;
   wire [7:0] rdata;
   wire [5:0] wkcfg;
   wire uf, run3, wkrun, wktick, irq;
   // Rows: address, write data, expected readback
   logic [23:0] tbl [12] = '{24'h1f_a5_a5, 24'h20_3c_3c, 24'h1e_ff_bb,
      24'h1e_00_00, 24'h23_3f_3f, 24'h23_80_00, 24'h23_c0_80, 24'h23_40_00,
      24'h21_12_00, 24'h22_34_00, 24'h40_ff_00, 24'h32_03_03};
   rtw_timer3_wakeup u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata), .t0_underflow_in(ev[0]),
      .t1_underflow_in(ev[1]), .tx_end_in(ev[2]), .rx_nibble_in(ev[3]),
      .lfo_clk_in(low_freq_oscillator), .t3_underflow_out(uf), .t3_running_out(run3),
      .wk_running_out(wkrun), .wk_cfg_out(wkcfg), .wk_tick_out(wktick),
      .irq_out(irq));
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (wktick === 1'b1) n_tick <= n_tick + 1;
   always @(posedge clk_in) if (uf === 1'b1) n_uf <= n_uf + 1;
   task automatic stop_test;
      $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read only; the caller judges v when the value may lie in a window
   task automatic rv(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rv(a);
      chk(e, v);
   endtask
   task automatic pe(input int i, input int n);
      repeat (n) begin
         @(posedge clk_in);
         ev[i] <= 1'b1;
         @(posedge clk_in);
         ev[i] <= 1'b0;
      end
   endtask
   // Slow pin toggles far apart so the synchroniser sees every edge
   task automatic lt(input int n);
      repeat (n) begin
         @(posedge clk_in);
         low_freq_oscillator <= ~low_freq_oscillator;
         repeat (10) @(posedge clk_in);
      end
   endtask
   initial begin
      #300000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      foreach (tbl[i]) begin
         wr(tbl[i][23:16], tbl[i][15:8]);
         rc(tbl[i][23:16], tbl[i][7:0]);
      end
      wr(8'h1f, 8'h00);
      wr(8'h20, 8'h02);
      wr(8'h1e, 8'h02);
      wr(8'h33, 8'h01);
      rc(8'h22, 8'h02);
      pe(1, 2);
      rc(8'h22, 8'h02);
      wr(8'h20, 8'h09);
      pe(0, 1);
      rc(8'h22, 8'h01);
      pe(0, 2);
      rc(8'h30, 8'h01);
      chk(8'h01, {7'h00, irq});
      chk(8'h00, {7'h00, run3});
      pe(0, 2);
      rc(8'h22, 8'h00);
      wr(8'h31, 8'h01);
      rc(8'h30, 8'h00);
      chk(8'h00, {7'h00, irq});
      wr(8'h32, 8'h00);
      wr(8'h1e, 8'h0b);
      wr(8'h33, 8'h01);
      rc(8'h22, 8'h09);
      pe(1, 10);
      rc(8'h22, 8'h09);
      chk(8'h01, {7'h00, run3});
      chk(8'h02, n_uf[7:0]);
      rc(8'h30, 8'h01);
      chk(8'h00, {7'h00, irq});
      wr(8'h32, 8'h01);
      rc(8'h32, 8'h01);
      chk(8'h01, {7'h00, irq});
      wr(8'h31, 8'h01);
      wr(8'h33, 8'h02);
      // Tick phase is free running, so only a window of counts is fair
      wr(8'h1e, 8'h81);
      wr(8'h33, 8'h01);
      repeat (1000) @(posedge clk_in);
      rv(8'h22);
      chk(8'h01, {7'h00, v inside {8'h06, 8'h07}});
      // Around reception only status is read, never the live count
      pe(3, 1);
      rc(8'h30, 8'h02);
      chk(8'h00, {7'h00, run3});
      wr(8'h31, 8'h03);
      wr(8'h1e, 8'h00);
      wr(8'h33, 8'h01);
      repeat (30) @(posedge clk_in);
      rv(8'h22);
      chk(8'h01, {7'h00, v inside {[8'h03:8'h06]}});
      for (int m = 1; m < 4; m++) begin
         wr(8'h33, 8'h02);
         wr(8'h1e, {2'b00, m[1:0], 4'h0});
         if (m == 1) pe(2, 1);
         else lt(2);
         repeat (2) @(posedge clk_in);
         #1 chk(8'h01, {7'h00, run3});
      end
      wr(8'h1e, 8'h00);
      wr(8'h33, 8'h02);
      for (int s = 0; s < 4; s++) begin
         wr(8'h23, {6'h30, s[1:0]});
         n_tick = 0;
         lt(64);
         chk(s == 0 ? 8'd32 : 8'd32 >> (s + 2), n_tick[7:0]);
      end
      wr(8'h23, 8'h03);
      rc(8'h23, 8'h83);
      chk(8'h01, {7'h00, wkrun});
      chk(8'h03, {2'b00, wkcfg});
      wr(8'h23, 8'h40);
      rc(8'h23, 8'h00);
      chk(8'h00, {7'h00, wkrun});
      // Source ticks while the enable is low must be lost, not queued
      wr(8'h1e, 8'h02);
      wr(8'h33, 8'h01);
      ce <= 1'b0;
      pe(0, 3);
      ce <= 1'b1;
      rc(8'h22, 8'h09);
      pe(0, 1);
      rc(8'h22, 8'h08);
      wr(8'h1f, 8'h5a);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rc(8'h1f, 8'h00);
      rc(8'h23, 8'h00);
      stop_test();
   end
endmodule
bind rtw_timer3_wakeup rtw_timer3_wakeup_properties u_prop (.clk_in,
   .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_end_in,
   .rx_nibble_in, .lfo_clk_in, .t3_underflow_out, .t3_running_out,
   .wk_running_out, .wk_cfg_out, .wk_tick_out, .irq_out);
`default_nettype wire
